// ### dv/test_usb_endpoint_ctrl_desc_reply.sv
// Self-checking bench for the endpoint control and descriptor reply block
`timescale 1ns/1ns
module test_usb_endpoint_ctrl_desc_reply;
    logic sys_clk, rst, avs_read, avs_write, avs_waitrequest, txn_start, txn_is_in, txn_end, txn_ok;
    logic [10:0] avs_address, txn_bytes, max_packet_len, ep0_bytes;
    logic [31:0] avs_writedata, avs_readdata;
    logic [3:0] avs_byteenable;
    logic [12:0] fifo_count, reply_start_addr;
    logic reply_active, ep0_in_done, ep_data_toggle, ep_short_en, tog;
    logic [1:0] ep_resp, r;
    logic [9:0] reply_byte_count;
    logic [7:0] d;
    int n_fail, samples_checked, cycles;

    ued_endpoint_ctrl ued_endpoint_ctrl_i (.sys_clk(sys_clk), .rst(rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .txn_start(txn_start), .txn_is_in(txn_is_in), .txn_end(txn_end), .txn_ok(txn_ok),
        .txn_bytes(txn_bytes), .fifo_count(fifo_count), .max_packet_len(max_packet_len),
        .reply_active(reply_active), .ep0_in_done(ep0_in_done), .ep0_bytes(ep0_bytes),
        .ep_resp(ep_resp), .ep_data_toggle(ep_data_toggle), .ep_short_en(ep_short_en),
        .reply_start_addr(reply_start_addr), .reply_byte_count(reply_byte_count));
    ued_host_model ued_host_model_i (.sys_clk(sys_clk), .ep_resp(ep_resp), .txn_start(txn_start),
        .txn_is_in(txn_is_in), .txn_end(txn_end), .txn_ok(txn_ok), .txn_bytes(txn_bytes));

    always #2 sys_clk = ~sys_clk;

    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            end_sim();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk_val(input logic [15:0] g, input logic [15:0] e);
        samples_checked++;
        if (g !== e) begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk_val
    task automatic chk_reg(input logic [7:0] g, input logic [7:0] e);
        chk_val({8'h00, g}, {8'h00, e});
    endtask : chk_reg
    task automatic chk_resp(input logic [1:0] g, input logic [1:0] e);
        chk_val({14'h0000, g}, {14'h0000, e});
    endtask : chk_resp

    // One Avalon access, held until waitrequest is seen low
    task automatic bus(input logic wr, input logic [8:0] idx, input logic [7:0] wd, input logic [3:0] be,
            output logic [7:0] rd);
        @(posedge sys_clk);
        avs_address <= {idx, 2'b00};
        avs_write <= wr;
        avs_read <= ~wr;
        avs_writedata <= {24'h000000, wd};
        avs_byteenable <= be;
        do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata[7:0];
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus
    task automatic wr_reg(input logic [8:0] idx, input logic [7:0] wd);
        bus(1'b1, idx, wd, 4'h1, d);
    endtask : wr_reg
    task automatic chk_rd(input logic [8:0] idx, input logic [7:0] e);
        bus(1'b0, idx, 8'h00, 4'hf, d);
        chk_reg(d, e);
    endtask : chk_rd
    task automatic chk_ctrl(input logic [7:0] e);
        chk_rd(ued_pkg::UED_IDX_EP_CTRL, e | {3'h0, tog, 4'h0});
    endtask : chk_ctrl
    // Full transaction; an error-free one flips the expected toggle
    task automatic txn(input logic is_in, input logic ok, input logic [10:0] n);
        ued_host_model_i.start(is_in, r);
        ued_host_model_i.finish(ok, n);
        tog = tog ^ ok;
    endtask : txn

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        logic [8:0] idxs [6] = '{9'h11c, 9'h120, 9'h121, 9'h122, 9'h123, 9'h124};
        chk_resp(ep_resp, ued_pkg::UED_RSP_NAK);
        foreach (idxs[i]) chk_rd(idxs[i], ued_pkg::UED_REG_RESET);
    endtask : t_reset

    task automatic t_flow();
        fifo_count <= 13'd64;
        wr_reg(ued_pkg::UED_IDX_EP_CTRL, 8'h02);
        chk_ctrl(8'h02);
        ued_host_model_i.start(1'b1, r);
        chk_resp(r, ued_pkg::UED_RSP_NAK);
        ued_host_model_i.finish(1'b0, 11'd0);
        wr_reg(ued_pkg::UED_IDX_EP_CTRL, 8'h03);
        ued_host_model_i.start(1'b1, r);
        chk_resp(r, ued_pkg::UED_RSP_STALL);
        ued_host_model_i.finish(1'b0, 11'd0);
        wr_reg(ued_pkg::UED_IDX_EP_CTRL, 8'h00);
        ued_host_model_i.start(1'b1, r);
        chk_resp(r, ued_pkg::UED_RSP_GO);
        wr_reg(ued_pkg::UED_IDX_EP_CTRL, 8'h01);
        chk_resp(ep_resp, ued_pkg::UED_RSP_GO);
        ued_host_model_i.finish(1'b1, 11'd64);
        tog = ~tog;
        txn(1'b1, 1'b0, 11'd0);
        chk_resp(r, ued_pkg::UED_RSP_STALL);
        wr_reg(ued_pkg::UED_IDX_EP_CTRL, 8'h00);
        ued_host_model_i.start(1'b1, r);
        wr_reg(ued_pkg::UED_IDX_EP_CTRL, 8'h02);
        chk_ctrl(8'h00);
        ued_host_model_i.finish(1'b1, 11'd64);
        tog = ~tog;
        chk_ctrl(8'h02);
    endtask : t_flow

    task automatic t_toggle();
        wr_reg(ued_pkg::UED_IDX_EP_CTRL, 8'h08);
        tog = 1'b1;
        chk_ctrl(8'h00);
        chk_val({15'h0000, ep_data_toggle}, 16'h0001);
        wr_reg(ued_pkg::UED_IDX_EP_CTRL, 8'h0c);
        tog = 1'b0;
        chk_ctrl(8'h00);
        wr_reg(ued_pkg::UED_IDX_EP_CTRL, 8'h08);
        wr_reg(ued_pkg::UED_IDX_EP_CTRL, 8'h04);
        chk_ctrl(8'h00);
    endtask : t_toggle

    task automatic t_short();
        fifo_count <= 13'd10;
        txn(1'b1, 1'b0, 11'd0);
        chk_resp(r, ued_pkg::UED_RSP_NAK);
        wr_reg(ued_pkg::UED_IDX_EP_CTRL, 8'h40);
        txn(1'b1, 1'b1, 11'd10);
        chk_resp(r, ued_pkg::UED_RSP_GO);
        chk_ctrl(8'h00);
        chk_val({15'h0000, ep_short_en}, 16'h0000);
        fifo_count <= 13'd64;
        wr_reg(ued_pkg::UED_IDX_EP_CTRL, 8'h40);
        txn(1'b1, 1'b1, 11'd64);
        chk_ctrl(8'h40);
        fifo_count <= 13'd0;
        txn(1'b1, 1'b1, 11'd0);
        chk_resp(r, ued_pkg::UED_RSP_ZLP);
        chk_ctrl(8'h00);
    endtask : t_short

    task automatic t_autonak();
        logic [7:0] cfg [5] = '{8'h80, 8'h00, 8'h20, 8'ha0, 8'h80};
        logic [7:0] exp [5] = '{8'h82, 8'h02, 8'h20, 8'ha2, 8'h80};
        logic [10:0] len [5] = '{11'd64, 11'd10, 11'd10, 11'd10, 11'd64};
        logic okv [5] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
        for (int i = 0; i < 5; i++) begin
            wr_reg(ued_pkg::UED_IDX_EP_CTRL, cfg[i]);
            txn(1'b0, okv[i], len[i]);
            chk_ctrl(exp[i]);
        end
    endtask : t_autonak

    task automatic t_reply();
        wr_reg(ued_pkg::UED_IDX_ADDR_HI, 8'h11);
        wr_reg(ued_pkg::UED_IDX_ADDR_LO, 8'hff);
        chk_rd(ued_pkg::UED_IDX_ADDR_HI, 8'h11);
        chk_val({3'h0, reply_start_addr}, 16'h11ff);
        chk_rd(ued_pkg::UED_IDX_ADDR_LO, 8'hff);
        wr_reg(ued_pkg::UED_IDX_SIZE_HI, 8'h03);
        wr_reg(ued_pkg::UED_IDX_SIZE_LO, 8'hff);
        bus(1'b1, ued_pkg::UED_IDX_SIZE_LO, 8'h55, 4'h0, d);
        chk_val({6'h00, reply_byte_count}, 16'h03ff);
        wr_reg(ued_pkg::UED_IDX_ADDR_HI, 8'h00);
        wr_reg(ued_pkg::UED_IDX_ADDR_LO, 8'h30);
        for (int a = 0; a < 2; a++) begin
            @(posedge sys_clk);
            reply_active <= a[0];
            ep0_in_done <= 1'b1;
            ep0_bytes <= 11'd64;
            @(posedge sys_clk);
            ep0_in_done <= 1'b0;
            ep0_bytes <= 11'h7bf;
        end
        chk_rd(ued_pkg::UED_IDX_ADDR_HI, 8'h00);
        chk_rd(ued_pkg::UED_IDX_ADDR_LO, 8'h70);
        chk_rd(ued_pkg::UED_IDX_SIZE_HI, 8'h03);
        chk_rd(ued_pkg::UED_IDX_SIZE_LO, 8'hbf);
    endtask : t_reply

    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : end_sim

    initial begin
        sys_clk = 1'b0;
        rst = 1'b1;
        {avs_read, avs_write, reply_active, ep0_in_done, tog} = 5'h00;
        avs_address = 11'h000;
        avs_writedata = 32'h00000000;
        avs_byteenable = 4'h0;
        fifo_count = 13'h0000;
        max_packet_len = 11'd64;
        ep0_bytes = 11'h000;
        repeat (8) @(posedge sys_clk);
        rst <= 1'b0;
        t_reset();
        t_flow();
        t_toggle();
        t_short();
        t_autonak();
        t_reply();
        end_sim();
    end
endmodule : test_usb_endpoint_ctrl_desc_reply

// ### dv/ued_host_model.sv
// Host-side token model driving the endpoint transaction link
`timescale 1ns/1ns
module ued_host_model (
    input wire logic sys_clk,
    input wire logic [1:0] ep_resp,
    output logic txn_start,
    output logic txn_is_in,
    output logic txn_end,
    output logic txn_ok,
    output logic [10:0] txn_bytes
);
    initial begin
        txn_start = 1'b0;
        txn_is_in = 1'b0;
        txn_end = 1'b0;
        txn_ok = 1'b0;
        txn_bytes = 11'h000;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Token phase; qualifiers are scrambled once the pulse has been taken
    task automatic start(input logic is_in, output logic [1:0] resp);
        @(posedge sys_clk);
        txn_start <= 1'b1;
        txn_is_in <= is_in;
        @(posedge sys_clk);
        txn_start <= 1'b0;
        txn_is_in <= ~is_in;
        @(posedge sys_clk);
        resp = ep_resp;
    endtask : start

    // Handshake phase; never overlaps a token phase
    task automatic finish(input logic ok, input logic [10:0] bytes);
        @(posedge sys_clk);
        txn_end <= 1'b1;
        txn_ok <= ok;
        txn_bytes <= bytes;
        @(posedge sys_clk);
        txn_end <= 1'b0;
        txn_ok <= ~ok;
        txn_bytes <= ~bytes;
    endtask : finish
endmodule : ued_host_model

// ### rtl/ued_endpoint_ctrl.sv
// Endpoint transaction control and descriptor reply pointers behind an Avalon-MM slave
//
// Local design decision: the Avalon-MM slave port.
`timescale 1ns/1ns
module ued_endpoint_ctrl #(
    parameter int MAX_LEN_W = ued_pkg::UED_LEN_W
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [10:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic txn_start,
    input wire logic txn_is_in,
    input wire logic txn_end,
    input wire logic txn_ok,
    input wire logic [MAX_LEN_W-1:0] txn_bytes,
    input wire logic [ued_pkg::UED_FIFO_W-1:0] fifo_count,
    input wire logic [MAX_LEN_W-1:0] max_packet_len,
    input wire logic reply_active,
    input wire logic ep0_in_done,
    input wire logic [ued_pkg::UED_LEN_W-1:0] ep0_bytes,
    output logic [1:0] ep_resp,
    output logic ep_data_toggle,
    output logic ep_short_en,
    output logic [ued_pkg::UED_ADDR_W-1:0] reply_start_addr,
    output logic [ued_pkg::UED_SIZE_W-1:0] reply_byte_count
);

    typedef struct packed {
        logic waitreq;
        logic [31:0] rdata;
        logic auto_nak_on_complete;
        logic short_packet_enable;
        logic short_out_autonak_disable;
        logic forced_nak;
        logic forced_stall;
        logic data_toggle;
        logic pend_nak;
        logic busy;
        logic is_in;
        logic [1:0] resp;
    } ued_main_state_type;

    ued_main_state_type r;
    ued_main_state_type r_nxt;
    logic accept;
    logic aligned;
    logic [8:0] idx;
    logic wr_lane;
    logic wr_ctl;
    logic [7:0] ctl_byte;
    logic [7:0] a_hi;
    logic [7:0] a_lo;
    logic [7:0] s_hi;
    logic [7:0] s_lo;
    logic ptr_adv;
    logic fifo_full_pkt;
    logic sent_short;
    logic [7:0] wd;

    ////////////////////////////////////////////////////////////////////////////////
    // Bus decode
    assign accept = (avs_read || avs_write) && r.waitreq;
    assign aligned = (avs_address[1:0] == 2'h0);
    assign idx = avs_address[10:2];
    assign wd = avs_writedata[7:0];
    // Writes land at the edge where the master sees waitrequest low
    assign wr_lane = avs_write && !r.waitreq && avs_byteenable[0] && aligned;
    assign wr_ctl = wr_lane && (idx == ued_pkg::UED_IDX_EP_CTRL);
    assign ptr_adv = ep0_in_done && reply_active;
    assign fifo_full_pkt = (fifo_count >= ued_pkg::UED_FIFO_W'(max_packet_len));
    assign sent_short = (txn_bytes < max_packet_len);

    // Strobe bits have no storage and read back as zero
    assign ctl_byte = {r.auto_nak_on_complete, r.short_packet_enable, r.short_out_autonak_disable,
        r.data_toggle, 2'b00, r.forced_nak, r.forced_stall};

    ////////////////////////////////////////////////////////////////////////////////
    // Reply pointers
    ued_reply_ptr #(.WIDTH(ued_pkg::UED_ADDR_W), .COUNT_DOWN(1'b0)) u_addr (
        .sys_clk(sys_clk),
        .rst(rst),
        .wr_hi(wr_lane && idx == ued_pkg::UED_IDX_ADDR_HI),
        .wr_lo(wr_lane && idx == ued_pkg::UED_IDX_ADDR_LO),
        .wdata(wd),
        .rd_hi(accept && avs_read && aligned && idx == ued_pkg::UED_IDX_ADDR_HI),
        .advance(ptr_adv),
        .amount(ep0_bytes),
        .value(reply_start_addr),
        .hi_byte(a_hi),
        .lo_byte(a_lo)
    );

    ued_reply_ptr #(.WIDTH(ued_pkg::UED_SIZE_W), .COUNT_DOWN(1'b1)) u_size (
        .sys_clk(sys_clk),
        .rst(rst),
        .wr_hi(wr_lane && idx == ued_pkg::UED_IDX_SIZE_HI),
        .wr_lo(wr_lane && idx == ued_pkg::UED_IDX_SIZE_LO),
        .wdata(wd),
        .rd_hi(accept && avs_read && aligned && idx == ued_pkg::UED_IDX_SIZE_HI),
        .advance(ptr_adv),
        .amount(ep0_bytes),
        .value(reply_byte_count),
        .hi_byte(s_hi),
        .lo_byte(s_lo)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        r_nxt = r;
        r_nxt.waitreq = !accept;
        if (accept && avs_read) begin
            r_nxt.rdata = 32'h0000_0000;
            if (aligned) begin
                case (idx)
                    ued_pkg::UED_IDX_EP_CTRL: r_nxt.rdata[7:0] = ctl_byte;
                    ued_pkg::UED_IDX_ADDR_HI: r_nxt.rdata[7:0] = a_hi;
                    ued_pkg::UED_IDX_ADDR_LO: r_nxt.rdata[7:0] = a_lo;
                    ued_pkg::UED_IDX_SIZE_HI: r_nxt.rdata[7:0] = s_hi;
                    ued_pkg::UED_IDX_SIZE_LO: r_nxt.rdata[7:0] = s_lo;
                    default: r_nxt.rdata[7:0] = 8'h00;
                endcase
            end
        end

        // Answer is fixed at the token; later control writes wait for the next one
        if (txn_start) begin
            r_nxt.busy = 1'b1;
            r_nxt.is_in = txn_is_in;
            if (r.forced_stall) begin
                r_nxt.resp = ued_pkg::UED_RSP_STALL;
            end else if (r.forced_nak) begin
                r_nxt.resp = ued_pkg::UED_RSP_NAK;
            end else if (!txn_is_in || fifo_full_pkt) begin
                r_nxt.resp = ued_pkg::UED_RSP_GO;
            end else if (!r.short_packet_enable) begin
                r_nxt.resp = ued_pkg::UED_RSP_NAK;
            end else if (fifo_count == '0) begin
                r_nxt.resp = ued_pkg::UED_RSP_ZLP;
            end else begin
                r_nxt.resp = ued_pkg::UED_RSP_GO;
            end
        end

        // Hardware events that clear come before software writes
        if (txn_end && txn_ok) begin
            r_nxt.data_toggle = !r.data_toggle;
            if (r.is_in && sent_short) begin
                r_nxt.short_packet_enable = 1'b0;
            end
        end

        if (wr_ctl) begin
            r_nxt.auto_nak_on_complete = wd[ued_pkg::UED_BIT_AUTO_NAK];
            r_nxt.short_out_autonak_disable = wd[ued_pkg::UED_BIT_SHORT_DIS];
            r_nxt.forced_stall = wd[ued_pkg::UED_BIT_FSTALL];
            if (wd[ued_pkg::UED_BIT_SHORT_EN]) begin
                r_nxt.short_packet_enable = 1'b1;
            end else if (!(txn_end && txn_ok && r.is_in && sent_short)) begin
                r_nxt.short_packet_enable = 1'b0;
            end
            if (wd[ued_pkg::UED_BIT_TOG_CLR]) begin
                r_nxt.data_toggle = 1'b0;
            end else if (wd[ued_pkg::UED_BIT_TOG_SET]) begin
                r_nxt.data_toggle = 1'b1;
            end
            if (!wd[ued_pkg::UED_BIT_FNAK]) begin
                r_nxt.forced_nak = 1'b0;
                r_nxt.pend_nak = 1'b0;
            end else if (r.busy) begin
                r_nxt.pend_nak = 1'b1;
            end else begin
                r_nxt.forced_nak = 1'b1;
            end
        end

        // Hardware sets come last so they win over a same-cycle clear
        if (txn_end) begin
            r_nxt.busy = 1'b0;
            if (r_nxt.pend_nak) begin
                r_nxt.forced_nak = 1'b1;
                r_nxt.pend_nak = 1'b0;
            end
            if (txn_ok && r.auto_nak_on_complete) begin
                r_nxt.forced_nak = 1'b1;
            end else if (txn_ok && !r.is_in && sent_short && !r.short_out_autonak_disable) begin
                r_nxt.forced_nak = 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            r <= '{waitreq: 1'b1, resp: ued_pkg::UED_RSP_NAK, default: '0};
        end else begin
            r <= r_nxt;
        end
    end

    assign avs_readdata = r.rdata;
    assign avs_waitrequest = r.waitreq;
    assign ep_resp = r.resp;
    assign ep_data_toggle = r.data_toggle;
    assign ep_short_en = r.short_packet_enable;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    sequence s_clean_end;
        txn_end && txn_ok && !wr_ctl;
    endsequence

    a_auto_nak_set: assert property (
        s_clean_end and r.auto_nak_on_complete |=> r.forced_nak)
        else $error("auto NAK on complete missed");
    a_short_out_nak: assert property (
        s_clean_end and !r.is_in && sent_short && !r.short_out_autonak_disable |=> r.forced_nak)
        else $error("short OUT did not force NAK");
    a_auto_over_dis: assert property (
        s_clean_end and r.auto_nak_on_complete && r.short_out_autonak_disable |=> r.forced_nak)
        else $error("auto NAK lost to disable bit");
    a_short_clear: assert property (
        s_clean_end and r.is_in && sent_short |=> !r.short_packet_enable)
        else $error("short enable not cleared");
    a_full_keep: assert property (
        s_clean_end and r.is_in && txn_bytes == max_packet_len && r.short_packet_enable |=> r.short_packet_enable)
        else $error("short enable cleared on full packet");
    a_short_send: assert property (
        txn_start && txn_is_in && !r.forced_stall && !r.forced_nak && r.short_packet_enable
        && fifo_count != '0 |=> ep_resp == ued_pkg::UED_RSP_GO)
        else $error("short packet not sent");
    a_zlp_answer: assert property (
        txn_start && txn_is_in && !r.forced_stall && !r.forced_nak && r.short_packet_enable
        && fifo_count == '0 |=> ep_resp == ued_pkg::UED_RSP_ZLP)
        else $error("zero length packet not chosen");
    a_nak_answer: assert property (
        txn_start && r.forced_nak && !r.forced_stall |=> ep_resp == ued_pkg::UED_RSP_NAK)
        else $error("forced NAK not answered");
    a_stall_wins: assert property (
        txn_start && r.forced_stall |=> ep_resp == ued_pkg::UED_RSP_STALL)
        else $error("STALL did not override");
    a_stall_defer: assert property (
        r.busy && !txn_start |=> $stable(ep_resp))
        else $error("answer changed mid transaction");
    a_nak_defer: assert property (
        wr_ctl && wd[ued_pkg::UED_BIT_FNAK] && r.busy && !r.forced_nak && !txn_end ##1 !txn_end
        |-> !r.forced_nak)
        else $error("forced NAK set during transaction");
    a_nak_now: assert property (
        wr_ctl && wd[ued_pkg::UED_BIT_FNAK] && !r.busy |=> r.forced_nak)
        else $error("forced NAK not set at once");
    a_toggle_clr_wins: assert property (
        wr_ctl && wd[ued_pkg::UED_BIT_TOG_CLR] && wd[ued_pkg::UED_BIT_TOG_SET] |=> !ep_data_toggle)
        else $error("toggle clear did not win");
    a_toggle_stat_read: assert property (
        accept && avs_read && aligned && idx == ued_pkg::UED_IDX_EP_CTRL
        |=> !avs_waitrequest && avs_readdata[4] == $past(r.data_toggle) && avs_readdata[3:2] == 2'b00)
        else $error("toggle status read wrong");

    ////////////////////////////////////////////////////////////////////////////////
    // Bus answer, toggle, forced NAK, short enable and answer choice
    sequence s_bus_answer;
        !avs_waitrequest ##1 avs_waitrequest;
    endsequence

    a_bus_answer: assert property (
        accept |=> s_bus_answer)
        else $error("waitrequest not low for one cycle");
    a_rdata_upper: assert property (
        accept && avs_read |=> avs_readdata[31:8] == 24'h000000)
        else $error("read data upper bits not zero");
    a_toggle_flip: assert property (
        s_clean_end |=> ep_data_toggle != $past(r.data_toggle))
        else $error("toggle did not flip");
    a_toggle_set: assert property (
        wr_ctl && wd[ued_pkg::UED_BIT_TOG_SET] && !wd[ued_pkg::UED_BIT_TOG_CLR] |=> ep_data_toggle)
        else $error("toggle set ignored");
    a_toggle_clr: assert property (
        wr_ctl && wd[ued_pkg::UED_BIT_TOG_CLR] |=> !ep_data_toggle)
        else $error("toggle clear ignored");
    a_pend_land: assert property (
        txn_end && r.pend_nak && !wr_ctl |=> r.forced_nak)
        else $error("pending NAK did not land");
    a_nak_release: assert property (
        wr_ctl && !wd[ued_pkg::UED_BIT_FNAK] && !txn_end |=> !r.forced_nak)
        else $error("forced NAK not released");
    a_short_set: assert property (
        wr_ctl && wd[ued_pkg::UED_BIT_SHORT_EN] |=> ep_short_en)
        else $error("short enable write lost");
    a_out_go: assert property (
        txn_start && !txn_is_in && !r.forced_stall && !r.forced_nak |=> ep_resp == ued_pkg::UED_RSP_GO)
        else $error("OUT not accepted");
    a_in_nak_wait: assert property (
        txn_start && txn_is_in && !r.forced_stall && !r.forced_nak && !r.short_packet_enable
        && !fifo_full_pkt |=> ep_resp == ued_pkg::UED_RSP_NAK)
        else $error("partial FIFO answered without short enable");

endmodule : ued_endpoint_ctrl

// ### rtl/ued_pkg.sv
// Constants and types for the endpoint control and descriptor reply block
// How it works
// - With auto-NAK-on-complete set, an error-free finished transaction sets forced NAK.
// - With short packet enabled, FIFO data below max length goes out on IN.
// - A sent short packet clears short enable; a full-length packet leaves it set.
// - Short enable with an empty FIFO answers the next IN with zero length.
// - Unless disabled, an error-free short OUT packet sets forced NAK.
// - Auto-NAK-on-complete governs forced NAK even when short-OUT auto-NAK is disabled.
// - The current data toggle reads back as a read-only status bit.
// - Writing toggle-set forces toggle to 1; clear wins when both are written.
// - Writing toggle-clear forces the data toggle to 0.
// - Forced NAK answers every transaction with NAK whatever the FIFO holds, unless forced STALL is set.
// - Forced NAK written during a transaction lands at its end, else at once.
// - Forced STALL answers with STALL and overrides forced NAK.
// - STALL set mid-transaction lets it finish and applies from the next one.
// - The 13-bit reply start address accepts any FIFO location 0x0000 to 0x1FFF.
// - Each finished endpoint-zero IN during reply advances the start address by bytes sent.
// - The 10-bit reply byte count accepts any value 0x000 to 0x3FF.
// - Each finished endpoint-zero IN during reply lowers the byte count by bytes sent.
package ued_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Register indices; byte address is four times the index
    localparam logic [8:0] UED_IDX_EP_CTRL = 9'h11c;
    localparam logic [8:0] UED_IDX_ADDR_HI = 9'h120;
    localparam logic [8:0] UED_IDX_ADDR_LO = 9'h121;
    localparam logic [8:0] UED_IDX_SIZE_HI = 9'h122;
    localparam logic [8:0] UED_IDX_SIZE_LO = 9'h123;
    localparam logic [7:0] UED_REG_RESET = 8'h00;

    ////////////////////////////////////////////////////////////////////////////////
    // Endpoint control field positions
    localparam int UED_BIT_AUTO_NAK = 7;
    localparam int UED_BIT_SHORT_EN = 6;
    localparam int UED_BIT_SHORT_DIS = 5;
    localparam int UED_BIT_TOG_STAT = 4;
    localparam int UED_BIT_TOG_SET = 3;
    localparam int UED_BIT_TOG_CLR = 2;
    localparam int UED_BIT_FNAK = 1;
    localparam int UED_BIT_FSTALL = 0;

    ////////////////////////////////////////////////////////////////////////////////
    // Pointer, packet length and FIFO count widths
    localparam int UED_ADDR_W = 13;
    localparam int UED_SIZE_W = 10;
    localparam int UED_LEN_W = 11;
    localparam int UED_FIFO_W = 13;

    typedef enum logic [1:0] {
        UED_RSP_GO = 2'h0,
        UED_RSP_NAK = 2'h1,
        UED_RSP_STALL = 2'h2,
        UED_RSP_ZLP = 2'h3
    } ued_resp_type;

endpackage : ued_pkg

// ### rtl/ued_reply_ptr.sv
// Byte-split reply pointer with snapshot read and transfer advance
`timescale 1ns/1ns
module ued_reply_ptr #(
    parameter int WIDTH = 13,
    parameter bit COUNT_DOWN = 1'b0
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic wr_hi,
    input wire logic wr_lo,
    input wire logic [7:0] wdata,
    input wire logic rd_hi,
    input wire logic advance,
    input wire logic [ued_pkg::UED_LEN_W-1:0] amount,
    output logic [WIDTH-1:0] value,
    output logic [7:0] hi_byte,
    output logic [7:0] lo_byte
);

    typedef struct packed {
        logic [WIDTH-1:0] val;
        logic [7:0] shadow_lo;
    } ued_ptr_state_type;

    ued_ptr_state_type r;
    ued_ptr_state_type r_nxt;
    logic [15:0] wide;
    logic [15:0] step;

    ////////////////////////////////////////////////////////////////////////////////
    always_comb begin
        r_nxt = r;
        wide = 16'(r.val);
        step = 16'(amount);
        if (advance) begin
            if (COUNT_DOWN) begin
                r_nxt.val = (wide > step) ? WIDTH'(wide - step) : '0;
            end else begin
                r_nxt.val = WIDTH'(wide + step);
            end
        end
        // Software load wins over a same-cycle advance
        if (wr_hi) begin
            r_nxt.val = WIDTH'({wdata, r_nxt.val[7:0]});
        end
        if (wr_lo) begin
            r_nxt.val[7:0] = wdata;
        end
        // Low byte frozen at the high-byte read so the pair is coherent
        if (rd_hi) begin
            r_nxt.shadow_lo = r.val[7:0];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            r <= '0;
        end else begin
            r <= r_nxt;
        end
    end

    assign value = r.val;
    assign hi_byte = 8'(wide >> 8);
    assign lo_byte = r.shadow_lo;

    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    a_ptr_load_exact: assert property (
        wr_lo && !wr_hi |=> value[7:0] == $past(wdata))
        else $error("pointer load not stored");
    a_ptr_advance_step: assert property (
        advance && !wr_hi && !wr_lo && !COUNT_DOWN |=> value == WIDTH'(16'($past(value)) + 16'($past(amount))))
        else $error("pointer did not advance by bytes sent");
    a_cnt_down_step: assert property (
        advance && !wr_hi && !wr_lo && COUNT_DOWN && 16'(value) > 16'(amount)
        |=> value == WIDTH'(16'($past(value)) - 16'($past(amount))))
        else $error("count did not drop by bytes sent");

endmodule : ued_reply_ptr
